/* logic/tmr_pkg.sv */
package tmr_pkg;

  // --------------------------------------------------------------
  // Register addresses on the special function register bus
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h91;
  localparam logic [7:0] ADDR_RELOAD_LOW_BYTE = 8'h92;
  localparam logic [7:0] ADDR_RELOAD_HIGH_BYTE = 8'h93;
  localparam logic [7:0] ADDR_COUNT_LOW_BYTE = 8'h94;
  localparam logic [7:0] ADDR_COUNT_HIGH_BYTE = 8'h95;

  // --------------------------------------------------------------
  // Control register field positions
  // --------------------------------------------------------------
  localparam int BIT_HIGH_OVERFLOW_FLAG = 7;
  localparam int BIT_LOW_OVERFLOW_FLAG = 6;
  localparam int BIT_LOW_BYTE_IRQ_ENABLE = 5;
  localparam int BIT_SOF_CAPTURE_ENABLE = 4;
  localparam int BIT_SPLIT_MODE = 3;
  localparam int BIT_RUN_CONTROL = 2;
  localparam int BIT_ALT_CLOCK_SELECT = 0;

  // --------------------------------------------------------------
  // Reset values and timing counts
  // --------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam int SYSTEM_CLOCK_DIVIDE = 12;
  localparam int EXT_DIVIDE = 8;
  localparam logic [3:0] DIV12_LAST = 4'(SYSTEM_CLOCK_DIVIDE - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

  // --------------------------------------------------------------
  // Whole state of the timer
  // --------------------------------------------------------------
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic sof_capture_enable;
    logic split_mode;
    logic run_control;
    logic alt_clock_select;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [3:0] div12;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [2:0] ext_div;
    logic [7:0] rdata;
  } tmr_state_t;

endpackage

/* logic/tmr_timer.sv */
`timescale 1ns/10ps
module tmr_timer
  import tmr_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_RD_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic HIGH_CLK_SEL_I,
  input wire logic LOW_CLK_SEL_I,
  input wire logic EXT_OSC_I,
  input wire logic SOF_I,
  input wire logic TIMER_IRQ_EN_I,
  output logic IRQ_O
);

  tmr_state_t s;
  tmr_state_t next_s;
  logic ext_rise;
  logic ext_tick;
  logic pre_tick;
  logic alt_tick;
  logic lo_tick;
  logic hi_tick;
  logic lo_run;
  logic hi_run;
  logic lo_wrap;
  logic hi_wrap;
  logic sof_evt;
  logic wr_ctrl;
  logic lo_zero;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------

  // One byte step: wrap to zero when zero is set (capture, or a 16-bit low carry), else reload
  function automatic logic [7:0] bump(input logic [7:0] v,
                                      input logic [7:0] r,
                                      input logic zero);
    logic [7:0] res;
    if (v == BYTE_ALL_ONES)
    begin
      res = zero ? RESET_BYTE : r;
    end
    else
    begin
      res = v + 8'h01;
    end
    return res;
  endfunction

  // --------------------------------------------------------------
  // Count sources and events
  // --------------------------------------------------------------

  // Edge detect reads only the second and third sync stages
  assign ext_rise = s.ext_s2 & ~s.ext_s3;
  assign ext_tick = ext_rise && (s.ext_div == EXT_DIV_LAST);
  assign pre_tick = (s.div12 == DIV12_LAST);
  assign alt_tick = s.alt_clock_select ? ext_tick : pre_tick;
  assign lo_tick = LOW_CLK_SEL_I ? 1'b1 : alt_tick;
  assign hi_tick = HIGH_CLK_SEL_I ? 1'b1 : alt_tick;
  // Whole 16-bit counter follows the low byte source
  assign lo_run = s.split_mode ? lo_tick : (s.run_control & lo_tick);
  assign lo_wrap = lo_run && (s.count_low_byte == BYTE_ALL_ONES);
  assign hi_run = s.split_mode ? (s.run_control & hi_tick) : lo_wrap;
  assign hi_wrap = hi_run && (s.count_high_byte == BYTE_ALL_ONES);
  // 16-bit mode: a low wrap alone carries, only a full wrap reloads
  assign lo_zero = s.sof_capture_enable | (~s.split_mode & ~hi_wrap);
  assign sof_evt = SOF_I & s.sof_capture_enable;
  assign wr_ctrl = SFR_WR_I && (SFR_ADDR_I == ADDR_TIMER_CONTROL);

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------

  // Software writes to counts win over counting; flag sets win
  always_comb
  begin
    next_s = s;
    next_s.ext_s1 = EXT_OSC_I;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    if (ext_rise)
    begin
      next_s.ext_div = s.ext_div + 3'h1;
    end
    next_s.div12 = pre_tick ? 4'h0 : s.div12 + 4'h1;
    // Counting, reload, or wrap to zero in capture mode or on a 16-bit low carry
    if (lo_run)
    begin
      next_s.count_low_byte = bump(s.count_low_byte,
        s.reload_low_byte, lo_zero);
    end
    if (hi_run)
    begin
      next_s.count_high_byte = bump(s.count_high_byte,
        s.reload_high_byte, s.sof_capture_enable);
    end
    // Capture of the current count on start of frame
    if (sof_evt)
    begin
      next_s.reload_low_byte = s.count_low_byte;
      next_s.reload_high_byte = s.count_high_byte;
    end
    // Register writes; bit 1 has no storage
    if (wr_ctrl)
    begin
      next_s.high_overflow_flag =
        SFR_WDATA_I[BIT_HIGH_OVERFLOW_FLAG];
      next_s.low_overflow_flag = SFR_WDATA_I[BIT_LOW_OVERFLOW_FLAG];
      next_s.low_byte_irq_enable = SFR_WDATA_I[BIT_LOW_BYTE_IRQ_ENABLE];
      next_s.sof_capture_enable = SFR_WDATA_I[BIT_SOF_CAPTURE_ENABLE];
      next_s.split_mode = SFR_WDATA_I[BIT_SPLIT_MODE];
      next_s.run_control = SFR_WDATA_I[BIT_RUN_CONTROL];
      next_s.alt_clock_select = SFR_WDATA_I[BIT_ALT_CLOCK_SELECT];
    end
    if (SFR_WR_I && SFR_ADDR_I == ADDR_RELOAD_LOW_BYTE)
    begin
      next_s.reload_low_byte = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == ADDR_RELOAD_HIGH_BYTE)
    begin
      next_s.reload_high_byte = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == ADDR_COUNT_LOW_BYTE)
    begin
      next_s.count_low_byte = SFR_WDATA_I;
    end
    if (SFR_WR_I && SFR_ADDR_I == ADDR_COUNT_HIGH_BYTE)
    begin
      next_s.count_high_byte = SFR_WDATA_I;
    end
    // Hardware sets beat a same-cycle software clear
    if (lo_wrap)
    begin
      next_s.low_overflow_flag = 1'b1;
    end
    if (hi_wrap || sof_evt)
    begin
      next_s.high_overflow_flag = 1'b1;
    end
    // Read data captured on the strobe, held until the next one
    if (SFR_RD_I)
    begin
      case (SFR_ADDR_I)
        ADDR_TIMER_CONTROL:
        begin
          next_s.rdata = {s.high_overflow_flag, s.low_overflow_flag,
            s.low_byte_irq_enable, s.sof_capture_enable, s.split_mode,
            s.run_control, 1'b0, s.alt_clock_select};
        end
        ADDR_RELOAD_LOW_BYTE:
        begin
          next_s.rdata = s.reload_low_byte;
        end
        ADDR_RELOAD_HIGH_BYTE:
        begin
          next_s.rdata = s.reload_high_byte;
        end
        ADDR_COUNT_LOW_BYTE:
        begin
          next_s.rdata = s.count_low_byte;
        end
        ADDR_COUNT_HIGH_BYTE:
        begin
          next_s.rdata = s.count_high_byte;
        end
        default:
        begin
          next_s.rdata = RESET_BYTE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------

  // Synchronous reset zeroes everything
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------

  // Request stays up while a gated flag stays set
  assign IRQ_O = TIMER_IRQ_EN_I & (s.high_overflow_flag |
    (s.low_byte_irq_enable & s.low_overflow_flag));
  assign SFR_RDATA_O = s.rdata;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  logic wr_any;
  logic wr_count;
  assign wr_any = SFR_WR_I;
  assign wr_count = wr_any && (SFR_ADDR_I == ADDR_COUNT_LOW_BYTE ||
    SFR_ADDR_I == ADDR_COUNT_HIGH_BYTE);

  sequence full_wrap_s;
    !s.split_mode && !s.sof_capture_enable && lo_run &&
      s.count_low_byte == 8'hFF && s.count_high_byte == 8'hFF && !wr_any;
  endsequence

  sequence prescale_s;
    pre_tick ##1 !pre_tick [*8];
  endsequence

  AST_RELOAD16: assert property (full_wrap_s |=>
    {s.count_high_byte, s.count_low_byte} ==
    {$past(s.reload_high_byte), $past(s.reload_low_byte)} &&
    s.high_overflow_flag)
    else $error("16-bit wrap did not reload");
  AST_CARRY16: assert property (!s.split_mode &&
    !s.sof_capture_enable && lo_wrap && s.count_high_byte != 8'hFF &&
    !wr_count |=> s.count_low_byte == 8'h00 &&
    s.count_high_byte == $past(s.count_high_byte) + 8'h01)
    else $error("16-bit carry did not roll low byte to zero");
  AST_LOW_FLAG: assert property (lo_wrap |=> s.low_overflow_flag)
    else $error("low wrap did not set flag");
  AST_FLAG_STICKY: assert property ($fell(s.high_overflow_flag) |->
    $past(RST_I) || ($past(wr_ctrl) &&
    !$past(SFR_WDATA_I[BIT_HIGH_OVERFLOW_FLAG])))
    else $error("high flag cleared without a write");
  AST_BIT1_ZERO: assert property (SFR_RD_I &&
    SFR_ADDR_I == ADDR_TIMER_CONTROL |=> SFR_RDATA_O[1] == 1'b0)
    else $error("unused control bit read nonzero");
  AST_STOPPED: assert property (!s.run_control && !s.split_mode &&
    !wr_any ##1 !wr_any |=> $stable(s.count_low_byte))
    else $error("stopped 16-bit timer moved");
  AST_SPLIT_LOW_RUNS: assert property (s.split_mode &&
    !s.run_control && LOW_CLK_SEL_I && !wr_any &&
    !(s.count_low_byte == 8'hFF && s.reload_low_byte == 8'hFF) |=>
    s.count_low_byte != $past(s.count_low_byte) &&
    s.count_high_byte == $past(s.count_high_byte))
    else $error("split run gating wrong");
  AST_SOF_CAPTURE: assert property (sof_evt && !wr_any |=>
    s.reload_low_byte == $past(s.count_low_byte) &&
    s.reload_high_byte == $past(s.count_high_byte) &&
    s.high_overflow_flag)
    else $error("start of frame capture missed");
  AST_LOW_IRQ: assert property (lo_wrap && s.low_byte_irq_enable &&
    TIMER_IRQ_EN_I && !wr_any ##1 TIMER_IRQ_EN_I |-> IRQ_O)
    else $error("low byte interrupt missing");
  AST_DIV12: assert property (prescale_s |->
    ##1 !pre_tick [*3] ##1 pre_tick)
    else $error("divide by 12 period wrong");
  // Pin level seen two and three edges back, i.e. after both sync flops
  AST_EXT_SYNC: assert property (ext_tick |->
    $past(EXT_OSC_I, 2) && !$past(EXT_OSC_I, 3))
    else $error("external tick not synchronised");

endmodule

/* tb/tmr_core_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// Processor core side of the register bus
// ------------------------------------------------
module tmr_core_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  // Idle bus until the first access
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end

  // Called at a falling edge; the next rising edge takes the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d; // Stale data never looks valid
    @(negedge clk_i); // Idle edge so back-to-back strobes never merge
  endtask

  // Read data lands on the taking edge and is sampled at the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
    @(negedge clk_i); // Idle edge so back-to-back strobes never merge
  endtask
endmodule

/* tb/tmr_timer_tb.sv */
`timescale 1ns/10ps
module tmr_timer_tb;
  typedef struct {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } tmr_row_t;

  // ------------------------------------------------
  // Clock, pins and the design
  // ------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic lsel = 1'b0;
  logic ext = 1'b0;
  logic sof = 1'b0;
  logic irq_en = 1'b0;
  logic irq;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd;
  int error_cnt = 0;
  int n_checks = 0;
  // Stopped timer, so every register reads back steady
  tmr_row_t rows [7] = '{'{8'h93, 8'hA5, 8'hA5}, '{8'h92, 8'h5A, 8'h5A},
    '{8'h94, 8'h3C, 8'h3C}, '{8'h95, 8'hC3, 8'hC3},
    '{8'h91, 8'h03, 8'h01}, '{8'h96, 8'h77, 8'h00},
    '{8'h91, 8'h00, 8'h00}};

  always #12.5 clk = ~clk;

  tmr_timer u_tmr_timer (.SYS_CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_WDATA_I(wdata), .SFR_RD_I(rd), .SFR_RDATA_O(rdata),
    .HIGH_CLK_SEL_I(hsel), .LOW_CLK_SEL_I(lsel), .EXT_OSC_I(ext),
    .SOF_I(sof), .TIMER_IRQ_EN_I(irq_en), .IRQ_O(irq));

  tmr_core_model u_tmr_core_model (.clk_i(clk), .rdata_i(rdata),
    .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

  // ------------------------------------------------
  // Compare and report helpers
  // ------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_tmr_core_model.rd(a, v);
    chk(v, exp);
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_tmr_core_model.wr(a, d);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the longest sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("Error %0t: run did not finish", $time);
    wrap_up();
  end

  // ------------------------------------------------
  // Main sequence, inputs change at falling edges
  // ------------------------------------------------
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i])
    begin
      w(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    $display("Register rows done");
    // Reset in mid-run wipes written values
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rchk(8'h93, 8'h00);
    $display("Reset test done");
    // 16-bit wrap; low irq enable left off in this mode
    lsel = 1'b1;
    irq_en = 1'b1;
    w(8'h92, 8'h34);
    w(8'h93, 8'h12);
    w(8'h94, 8'hFE);
    w(8'h95, 8'hFF);
    w(8'h91, 8'h04);
    repeat (20) @(negedge clk);
    rchk(8'h91, 8'hC4);
    chk({7'h00, irq}, 8'h01);
    w(8'h91, 8'h00);
    rchk(8'h95, 8'h12);
    chk({7'h00, irq}, 8'h00);
    // Low byte carry only; stop lands on the wrap edge, so set wins
    w(8'h94, 8'hFE);
    w(8'h95, 8'h00);
    w(8'h91, 8'h04);
    w(8'h91, 8'h00);
    rchk(8'h94, 8'h00);
    rchk(8'h95, 8'h01);
    rchk(8'h91, 8'h40);
    $display("Reload test done");
    // Split mode, high byte held by run bit
    hsel = 1'b1;
    w(8'h95, 8'h77);
    w(8'h92, 8'hF0);
    w(8'h94, 8'hFE);
    w(8'h91, 8'h08);
    repeat (40) @(negedge clk);
    rchk(8'h91, 8'h48);
    rchk(8'h95, 8'h77);
    chk({7'h00, irq}, 8'h00);
    w(8'h91, 8'h28);
    repeat (20) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    w(8'h91, 8'h00);
    $display("Split test done");
    // Capture of a frozen count on one frame pulse
    w(8'h94, 8'hCD);
    w(8'h95, 8'hAB);
    w(8'h91, 8'h10);
    sof = 1'b1;
    @(negedge clk);
    sof = 1'b0;
    rchk(8'h92, 8'hCD);
    rchk(8'h93, 8'hAB);
    rchk(8'h91, 8'h90);
    w(8'h91, 8'h00);
    $display("Capture test done");
    // Sixteen oscillator rising edges give two ticks
    lsel = 1'b0;
    w(8'h94, 8'h00);
    w(8'h95, 8'h00);
    w(8'h91, 8'h05);
    repeat (16)
    begin
      ext = 1'b1;
      repeat (2) @(negedge clk);
      ext = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (6) @(negedge clk);
    rchk(8'h94, 8'h02);
    $display("External clock test done");
    // Split capture, both bytes frozen: idle oscillator, run off
    w(8'h94, 8'h5A);
    w(8'h95, 8'hA5);
    w(8'h91, 8'h19);
    sof = 1'b1;
    @(negedge clk);
    sof = 1'b0;
    rchk(8'h92, 8'h5A);
    rchk(8'h93, 8'hA5);
    rchk(8'h91, 8'h99);
    $display("Split capture test done");
    wrap_up();
  end
endmodule
